// file: rtl/tcp_params.svh
// Offsets, field positions, codes and reset values of the timer channel
`ifndef TCP_PARAMS_SVH
`define TCP_PARAMS_SVH

`define TCP_OFS_CFG 8'h00
`define TCP_OFS_MODE 8'h04
`define TCP_OFS_CTL 8'h0C
`define TCP_OFS_IMR 8'h18
`define TCP_OFS_RIS 8'h1C
`define TCP_OFS_MIS 8'h20
`define TCP_OFS_ICR 8'h24
`define TCP_OFS_ILR 8'h28
`define TCP_OFS_MATCH 8'h30
`define TCP_OFS_PR 8'h38
`define TCP_OFS_PMR 8'h40
`define TCP_OFS_CNT 8'h48

`define TCP_CFG_32 3'h0
`define TCP_CFG_RTC 3'h1
`define TCP_CFG_16_BIT 2

`define TCP_MODE_AMS 3
`define TCP_MODE_CMR 2
`define TCP_MR_ONESHOT 2'h1
`define TCP_MR_PERIODIC 2'h2
`define TCP_MR_CAPTURE 2'h3

`define TCP_CTL_EN 0
`define TCP_CTL_STALL 1
`define TCP_CTL_EVT 3:2
`define TCP_CTL_RTCOV 4
`define TCP_CTL_INV 6
`define TCP_EVT_RISE 2'h0
`define TCP_EVT_FALL 2'h1

`define TCP_FL_TO 0
`define TCP_FL_CM 1
`define TCP_FL_CE 2
`define TCP_FL_RTC 3

`define TCP_RST_ILR 32'hFFFFFFFF
`define TCP_RST_MATCH 32'hFFFFFFFF
`define TCP_RST_CNT 32'hFFFFFFFF
`define TCP_RTC_START 32'h00000001
`define TCP_RTC_DIV_LAST 15'h7FFF

`endif

// file: rtl/tcp_pkg.sv
// Types of the timer channel
package tcp_pkg;
   typedef struct packed {
      logic [2:0] cfg;
      logic [3:0] mode;
      logic [6:0] ctl;
      logic [3:0] imr;
      logic [3:0] ris;
      logic [31:0] ilr;
      logic [31:0] mtch;
      logic [7:0] pr;
      logic [7:0] pmr;
      logic [31:0] cnt;
      logic [7:0] pcnt;
      logic [15:0] cap;
      logic [2:0] sync;
      logic [14:0] rdiv;
      logic pwm;
      logic pin;
      logic rd_pend;
      logic wr_pend;
      logic [7:0] addr;
      logic rdy;
      logic resp;
      logic [31:0] rdata;
   } tcp_state_s;

   typedef struct packed {
      logic sel;
      logic [1:0] trans;
      logic write;
      logic [7:0] addr;
      logic ready;
   } tcp_ahb_req_s;
endpackage : tcp_pkg

// file: rtl/tcp_timer.sv
// Timer channel: 32-bit, RTC, 16-bit timer, edge count, edge time, PWM
// Function
// - Edge-time mode ignores the prescaler; counter steps every clock.
// - Edge-time counter runs down freely from interval load, 0xFFFF at reset.
// - Capture kind 1 with mode field 3 selects edge-time capture.
// - Rising, falling or both capture edges per the control edge field.
// - Selected edge copies count to captured register, sets capture event flag.
// - Captured count holds until the next selected edge overwrites it.
// - After capture keep counting; at zero reload from interval load.
// - Interval load write in edge-time mode acts the next cycle.
// - Alternate mode 1, capture kind 0, mode field 2 selects PWM.
// - PWM counts down to zero, then reloads interval and prescale.
// - PWM mode sets no status flag.
// - PWM asserts at start value, deasserts at match value.
// - Invert bit complements the PWM output.
// - Interval load write in PWM changes the period next cycle.
// - Config 0 is 32-bit timer, 1 is RTC, 4 is 16-bit timers.
// - Mode field 1 is one-shot, 2 is periodic.
// - Writing 1 to timeout clear bit clears raw and masked timeout.
// - RTC on match reloads zero and keeps counting.
// - Edge count is kind 0 mode 3; stops after the edge count.
// - Prescale value and prescale match extend PWM counter and compare.
// - Each edge decrements; at match set flag, reload, clear enable.
`timescale 1ns/1ps
`include "tcp_params.svh"

module tcp_timer (
   input wire logic SYS_CLK_IN, // 200 MHz clock
   input wire logic SRST_IN, // Synchronous reset, high
   input wire logic HSEL_IN, // AHB slave select
   input wire logic [31:0] HADDR_IN, // AHB address
   input wire logic [1:0] HTRANS_IN, // AHB transfer type
   input wire logic HWRITE_IN, // AHB write
   input wire logic [31:0] HWDATA_IN, // AHB write data
   input wire logic HREADY_IN, // AHB bus ready
   output logic [31:0] HRDATA_OUT, // AHB read data
   output logic HREADYOUT_OUT, // AHB slave ready
   output logic HRESP_OUT, // AHB response, always OKAY
   input wire logic CAPTURE_PIN_ZERO_IN, // Capture pin, async
   output logic PWM_OUT // PWM output
);
   tcp_pkg::tcp_state_s s;
   tcp_pkg::tcp_state_s next_s;

   function automatic logic sel_edge(input logic [1:0] evt,
                                     input logic rise,
                                     input logic fall);
      if (evt == `TCP_EVT_RISE) begin
         sel_edge = rise;
      end else if (evt == `TCP_EVT_FALL) begin
         sel_edge = fall;
      end else begin
         sel_edge = rise | fall;
      end
   endfunction : sel_edge

   function automatic logic [31:0] rd_mux(input tcp_pkg::tcp_state_s r,
                                          input logic edge_time);
      rd_mux = 32'h00000000;
      case (r.addr)
         `TCP_OFS_CFG: rd_mux = {29'h0, r.cfg};
         `TCP_OFS_MODE: rd_mux = {28'h0000000, r.mode};
         `TCP_OFS_CTL: rd_mux = {25'h0, r.ctl};
         `TCP_OFS_IMR: rd_mux = {28'h0000000, r.imr};
         `TCP_OFS_RIS: rd_mux = {28'h0000000, r.ris};
         `TCP_OFS_MIS: rd_mux = {28'h0000000, r.ris & r.imr};
         `TCP_OFS_ILR: rd_mux = r.ilr;
         `TCP_OFS_MATCH: rd_mux = r.mtch;
         `TCP_OFS_PR: rd_mux = {24'h000000, r.pr};
         `TCP_OFS_PMR: rd_mux = {24'h000000, r.pmr};
         `TCP_OFS_CNT: rd_mux = edge_time ? {16'h0000, r.cap} : r.cnt;
         default: rd_mux = 32'h00000000;
      endcase
   endfunction : rd_mux

   tcp_pkg::tcp_ahb_req_s req;
   logic rise;
   logic fall;
   logic edge_hit;
   logic run;
   logic m32;
   logic mrtc;
   logic m16;
   logic timer_mode;
   logic pwm_mode;
   logic etime_mode;
   logic ecount_mode;
   logic [1:0] mr;
   logic [23:0] v24;
   logic [15:0] dec16;
   logic [3:0] set_fl;
   logic [3:0] clr_fl;
   logic start;
   logic ilr_wr;

   always_comb begin
      next_s = s;
      req = '{sel: HSEL_IN, trans: HTRANS_IN, write: HWRITE_IN,
              addr: HADDR_IN[7:0], ready: HREADY_IN};
      set_fl = 4'h0;
      clr_fl = 4'h0;
      start = 1'b0;
      ilr_wr = 1'b0;
      // First stage feeds only the second; edges use stages two and three
      next_s.sync = {s.sync[1], s.sync[0], CAPTURE_PIN_ZERO_IN};
      rise = s.sync[1] & ~s.sync[2];
      fall = ~s.sync[1] & s.sync[2];
      edge_hit = sel_edge(s.ctl[`TCP_CTL_EVT], rise, fall);
      mr = s.mode[1:0];
      m32 = (s.cfg == `TCP_CFG_32);
      mrtc = (s.cfg == `TCP_CFG_RTC);
      m16 = s.cfg[`TCP_CFG_16_BIT];
      pwm_mode = m16 & s.mode[`TCP_MODE_AMS] & ~s.mode[`TCP_MODE_CMR]
                 & (mr == `TCP_MR_PERIODIC);
      etime_mode = m16 & s.mode[`TCP_MODE_CMR]
                   & (mr == `TCP_MR_CAPTURE);
      ecount_mode = m16 & ~s.mode[`TCP_MODE_CMR]
                    & (mr == `TCP_MR_CAPTURE);
      timer_mode = ~s.mode[`TCP_MODE_AMS] & ((mr == `TCP_MR_ONESHOT)
                   | (mr == `TCP_MR_PERIODIC));
      // Stall is ignored in RTC mode when the override bit is set
      run = s.ctl[`TCP_CTL_EN] & ~(s.ctl[`TCP_CTL_STALL]
            & ~(mrtc & s.ctl[`TCP_CTL_RTCOV]));
      v24 = {s.pcnt, s.cnt[15:0]};
      dec16 = s.cnt[15:0] - 16'h0001;

      if (run) begin
         if (m32 && timer_mode) begin
            if (s.cnt == 32'h00000000) begin
               next_s.cnt = s.ilr;
               set_fl[`TCP_FL_TO] = 1'b1;
               if (mr == `TCP_MR_ONESHOT) begin
                  next_s.ctl[`TCP_CTL_EN] = 1'b0;
               end
            end else begin
               next_s.cnt = s.cnt - 32'h00000001;
            end
         end else if (mrtc) begin
            if (s.cnt == s.mtch) begin
               next_s.cnt = 32'h00000000;
               set_fl[`TCP_FL_RTC] = 1'b1;
            end else if (rise) begin
               // 32768 rising pin edges make one second
               if (s.rdiv == `TCP_RTC_DIV_LAST) begin
                  next_s.rdiv = 15'h0000;
                  next_s.cnt = s.cnt + 32'h00000001;
               end else begin
                  next_s.rdiv = s.rdiv + 15'h0001;
               end
            end
         end else if (pwm_mode || (m16 && timer_mode)) begin
            // Prescaler forms the upper eight bits of a 24-bit count
            if (v24 == 24'h000000) begin
               next_s.cnt = {16'h0000, s.ilr[15:0]};
               next_s.pcnt = s.pr;
               if (!pwm_mode) begin
                  set_fl[`TCP_FL_TO] = 1'b1;
                  if (mr == `TCP_MR_ONESHOT) begin
                     next_s.ctl[`TCP_CTL_EN] = 1'b0;
                  end
               end
            end else begin
               {next_s.pcnt, next_s.cnt[15:0]} = v24 - 24'h000001;
            end
            if (pwm_mode) begin
               if (v24 == {s.pr, s.ilr[15:0]}) begin
                  next_s.pwm = 1'b1;
               end else if (v24 == {s.pmr, s.mtch[15:0]}) begin
                  next_s.pwm = 1'b0;
               end
            end
         end else if (etime_mode) begin
            if (s.cnt[15:0] == 16'h0000) begin
               next_s.cnt = {16'h0000, s.ilr[15:0]};
            end else begin
               next_s.cnt = {16'h0000, dec16};
            end
            if (edge_hit) begin
               next_s.cap = s.cnt[15:0];
               set_fl[`TCP_FL_CE] = 1'b1;
            end
         end else if (ecount_mode && edge_hit) begin
            if (dec16 == s.mtch[15:0]) begin
               set_fl[`TCP_FL_CM] = 1'b1;
               next_s.cnt = {16'h0000, s.ilr[15:0]};
               next_s.ctl[`TCP_CTL_EN] = 1'b0;
            end else begin
               next_s.cnt = {16'h0000, dec16};
            end
         end
      end

      // Register writes land in the data phase
      if (s.wr_pend) begin
         case (s.addr)
            `TCP_OFS_CFG: next_s.cfg = HWDATA_IN[2:0];
            `TCP_OFS_MODE: next_s.mode = HWDATA_IN[3:0];
            `TCP_OFS_CTL: begin
               next_s.ctl = HWDATA_IN[6:0];
               start = HWDATA_IN[`TCP_CTL_EN] & ~s.ctl[`TCP_CTL_EN];
            end
            `TCP_OFS_IMR: next_s.imr = HWDATA_IN[3:0];
            `TCP_OFS_ICR: clr_fl = HWDATA_IN[3:0];
            `TCP_OFS_ILR: begin
               next_s.ilr = HWDATA_IN;
               ilr_wr = 1'b1;
            end
            `TCP_OFS_MATCH: next_s.mtch = HWDATA_IN;
            `TCP_OFS_PR: next_s.pr = HWDATA_IN[7:0];
            `TCP_OFS_PMR: next_s.pmr = HWDATA_IN[7:0];
            default: ;
         endcase
      end

      if (start) begin
         next_s.rdiv = 15'h0000;
         next_s.pcnt = s.pr;
         if (mrtc) begin
            next_s.cnt = `TCP_RTC_START;
         end else if (m16) begin
            next_s.cnt = {16'h0000, s.ilr[15:0]};
         end else begin
            next_s.cnt = s.ilr;
         end
      end else if (ilr_wr && s.ctl[`TCP_CTL_EN] && !mrtc
                   && !ecount_mode) begin
         // New interval is counted from on the very next cycle
         next_s.pcnt = s.pr;
         next_s.cnt = m16 ? {16'h0000, HWDATA_IN[15:0]}
                          : HWDATA_IN;
      end

      // A hardware event in the clearing cycle survives the clear
      next_s.ris = (s.ris & ~clr_fl) | set_fl;
      next_s.pin = pwm_mode & (next_s.pwm ^ next_s.ctl[`TCP_CTL_INV]);

      // Reads take one wait state so read data comes from a flop
      next_s.wr_pend = 1'b0;
      if (s.rd_pend) begin
         next_s.rd_pend = 1'b0;
         next_s.rdy = 1'b1;
         next_s.rdata = rd_mux(s, etime_mode);
      end else if (req.sel && req.trans[1] && req.ready) begin
         next_s.wr_pend = req.write;
         next_s.rd_pend = ~req.write;
         next_s.rdy = req.write;
         next_s.addr = req.addr;
      end
      next_s.resp = 1'b0;
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         s <= '0;
         s.ilr <= `TCP_RST_ILR;
         s.mtch <= `TCP_RST_MATCH;
         s.cnt <= `TCP_RST_CNT;
         s.rdy <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign HRDATA_OUT = s.rdata;
   assign HREADYOUT_OUT = s.rdy;
   assign HRESP_OUT = s.resp;
   assign PWM_OUT = s.pin;
endmodule : tcp_timer

// file: verification/tcp_edge_src.sv
// Far-side model: drives edges onto the capture pin
`timescale 1ns/1ps
module tcp_edge_src (
   input wire logic clk_in, // Bench clock
   output logic pin_out // Capture pin level
);
   initial pin_out = 1'b0;
   // Each level is held w clocks; the three-flop synchroniser needs one
   task automatic pulses(input int n, input int w);
      repeat (n) begin
         repeat (w) @(posedge clk_in);
         pin_out <= 1'b1;
         repeat (w) @(posedge clk_in);
         pin_out <= 1'b0;
      end
   endtask : pulses
endmodule : tcp_edge_src

// file: verification/tcp_timer_assertions.sv
// Port-level checker of the timer channel and its bind
`timescale 1ns/1ps
module tcp_timer_chk (
   input wire logic SYS_CLK_IN, // Clock
   input wire logic SRST_IN, // Reset
   input wire logic HSEL_IN, // Select
   input wire logic [31:0] HADDR_IN, // Address
   input wire logic [1:0] HTRANS_IN, // Transfer type
   input wire logic HWRITE_IN, // Write
   input wire logic [31:0] HWDATA_IN, // Write data
   input wire logic HREADY_IN, // Bus ready
   input wire logic [31:0] HRDATA_OUT, // Read data
   input wire logic HREADYOUT_OUT, // Slave ready
   input wire logic HRESP_OUT, // Response
   input wire logic PWM_OUT // PWM level
);
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (SRST_IN);
   logic tk;
   logic wp;
   logic [7:0] wa;
   logic [3:0] mode;
   assign tk = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
   // Shadow of the mode register, followed from the bus
   always_ff @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         wp <= 1'b0;
         wa <= 8'h00;
         mode <= 4'h0;
      end else if (HREADY_IN) begin
         wp <= tk && HWRITE_IN;
         wa <= HADDR_IN[7:0];
         if (wp && wa == 8'h04) mode <= HWDATA_IN[3:0];
      end
   end
   property p_okay;
      HRESP_OUT == 1'b0;
   endproperty
   a_okay: assert property (p_okay) else $error("error response");
   property p_rd_wait;
      tk && !HWRITE_IN |=> !HREADYOUT_OUT ##1 HREADYOUT_OUT;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
   property p_wr_nowait;
      tk && HWRITE_IN |=> HREADYOUT_OUT;
   endproperty
   a_wr_nowait: assert property (p_wr_nowait) else $error("write waited");
   property p_one_wait;
      !HREADYOUT_OUT |=> HREADYOUT_OUT;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("long wait");
   property p_rd_hold;
      HREADYOUT_OUT && $past(HREADYOUT_OUT) |-> $stable(HRDATA_OUT);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_void;
      tk && !HWRITE_IN && HADDR_IN[7:0] inside {8'h08, 8'h24}
         |-> ##2 HRDATA_OUT == 32'h0;
   endproperty
   a_void: assert property (p_void) else $error("void read not zero");
   property p_pwm_off;
      mode != 4'hA ##1 mode != 4'hA |-> !PWM_OUT;
   endproperty
   a_pwm_off: assert property (p_pwm_off) else $error("stray pwm");
   property p_rst;
      $fell(SRST_IN) |-> HREADYOUT_OUT && !PWM_OUT && HRDATA_OUT == 32'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset state");
   c_rd: cover property (tk && !HWRITE_IN);
   c_mode: cover property (mode == 4'hA);
   c_pwm: cover property ($rose(PWM_OUT));
endmodule : tcp_timer_chk
bind tcp_timer tcp_timer_chk i_tcp_timer_chk (.SYS_CLK_IN(SYS_CLK_IN),
   .SRST_IN(SRST_IN), .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN),
   .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HWDATA_IN(HWDATA_IN),
   .HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT),
   .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT), .PWM_OUT(PWM_OUT));

// file: verification/tcp_timer_tb.sv
// Self-checking bench of the timer channel
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("unexpected %0t: %h vs %h", $time, g, e); end end
module tcp_timer_tb;
   logic clk = 0, rst = 1, sel = 0, wr = 0, rdy, pin, pwm;
   logic [1:0] tr = 0;
   logic [31:0] ad = 0, wd = 0, rd, r;
   int n_errors = 0, num_checks = 0, cyc = 0, n, c1, h;
   always #2.5 clk = ~clk;
   tcp_timer i_tcp_timer (.SYS_CLK_IN(clk), .SRST_IN(rst), .HSEL_IN(sel),
      .HADDR_IN(ad), .HTRANS_IN(tr), .HWRITE_IN(wr), .HWDATA_IN(wd),
      .HREADY_IN(rdy), .HRDATA_OUT(rd), .HREADYOUT_OUT(rdy),
      .HRESP_OUT(), .CAPTURE_PIN_ZERO_IN(pin), .PWM_OUT(pwm));
   tcp_edge_src i_tcp_edge_src (.clk_in(clk), .pin_out(pin));
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      sel <= 1'b1;
      tr <= 2'h2;
      wr <= w;
      ad <= {24'h0, a};
      do @(posedge clk); while (rdy !== 1'b1);
      sel <= 1'b0;
      tr <= 2'h0;
      wd <= d;
      do @(posedge clk); while (rdy !== 1'b1);
      r = rd;
   endtask : bus
   // Enable goes last so no field changes while the timer runs
   task automatic setup(input logic [31:0] c, m, l, t, k);
      bus(1, 8'h0C, 0);
      bus(1, 8'h00, c);
      bus(1, 8'h04, m);
      bus(1, 8'h28, l);
      bus(1, 8'h30, t);
      bus(1, 8'h0C, k);
   endtask : setup
   task automatic poll(input logic [31:0] m);
      n = 0;
      do begin
         bus(0, 8'h1C, 0);
         n++;
      end while ((r & m) == 0 && n < 300);
   endtask : poll
   task automatic wrap_up;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : wrap_up
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         n_errors++;
         wrap_up();
      end
   end
   initial begin
      void'($urandom(32'h4F3E162E));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      bus(0, 8'h28, 0);
      `CHK(r, 32'hFFFFFFFF)
      bus(0, 8'h08, 0);
      `CHK(r, 32'h0)
      for (int m = 1; m <= 2; m++) begin
         setup(0, m, 20 + $urandom % 30, 0, 0);
         bus(1, 8'h18, 1);
         bus(1, 8'h0C, 1);
         poll(1);
         `CHK(r[0], 1'b1)
         bus(0, 8'h0C, 0);
         `CHK(r[0], logic'(m == 2))
         bus(0, 8'h20, 0);
         `CHK(r[0], 1'b1)
         bus(1, 8'h24, 1);
         bus(0, 8'h1C, 0);
         `CHK(r[0], 1'b0)
      end
      // Match at the start value: reload to zero before any pin edge
      setup(1, 0, 0, 1, 1);
      i_tcp_edge_src.pulses(2, 2);
      bus(0, 8'h1C, 0);
      `CHK(r[3], 1'b1)
      bus(0, 8'h48, 0);
      `CHK(r, 32'h0)
      for (int e = 0; e < 3; e++) begin
         n = 1 + $urandom % 4;
         bus(1, 8'h24, 15);
         setup(4, 3, 10, 6, 1 + (e << 2));
         i_tcp_edge_src.pulses(n, 3);
         repeat (6) @(posedge clk);
         c1 = 10;
         h = 1;
         for (int k = 0; k < (e == 2 ? 2 * n : n); k++) begin
            if (h == 1) c1--;
            if (h == 1 && c1 == 6) begin
               c1 = 10;
               h = 0;
            end
         end
         bus(0, 8'h48, 0);
         `CHK(r, 32'(c1))
         bus(0, 8'h0C, 0);
         `CHK(r[0], h[0])
         bus(0, 8'h1C, 0);
         `CHK(r[1], ~h[0])
      end
      bus(1, 8'h0C, 0);
      bus(1, 8'h38, 32'hFF);
      bus(1, 8'h18, 4);
      setup(4, 7, 32'hFFFF, 0, 1);
      i_tcp_edge_src.pulses(1, 3);
      repeat (6) @(posedge clk);
      bus(0, 8'h20, 0);
      `CHK(r[2], 1'b1)
      bus(0, 8'h48, 0);
      c1 = r;
      // Edge is captured five counts after the enable lands
      `CHK(r, 32'h0000FFFA)
      bus(0, 8'h48, 0);
      `CHK(r, 32'(c1))
      i_tcp_edge_src.pulses(1, 20);
      repeat (6) @(posedge clk);
      bus(0, 8'h48, 0);
      // Rising edges 38 clocks apart: one count per clock, no prescale
      `CHK(r, 32'(c1 - 38))
      bus(1, 8'h28, 3);
      i_tcp_edge_src.pulses(1, 3);
      repeat (6) @(posedge clk);
      bus(0, 8'h48, 0);
      // New interval counts 3,2,1,0, reloads 3, so 2 is captured
      `CHK(r, 32'h2)
      bus(1, 8'h0C, 0);
      bus(1, 8'h38, 0);
      bus(1, 8'h24, 15);
      for (int v = 0; v < 3; v++) begin
         setup(4, 32'hA, 19, 4, v == 1 ? 32'h41 : 32'h1);
         if (v == 2) bus(1, 8'h28, 39);
         repeat (40) @(posedge clk);
         h = 0;
         repeat (200) @(posedge clk) h += (pwm === 1'b1);
         `CHK(h, v == 0 ? 150 : v == 1 ? 50 : 175)
      end
      bus(0, 8'h1C, 0);
      `CHK(r, 32'h0)
      wrap_up();
   end
endmodule : tcp_timer_tb
